// >>> bench/mis_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// host controller on the register port
// --------
module mis_host_model (
   input wire logic core_clk_i,
   input wire logic [23:0] rdata_i,
   input wire logic rvalid_i,
   output var logic rd_o,
   output var logic wr_o,
   output var logic [7:0] addr_o,
   output var logic [23:0] wdata_o
);
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 24'h000000;
   end
   // one access, entered just after a rising edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d,
      output logic [23:0] q);
      rd_o <= !w;
      wr_o <= w;
      addr_o <= a;
      wdata_o <= d;
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      addr_o <= ~a; // released lines keep no stale value
      wdata_o <= ~d;
      @(posedge core_clk_i);
      q = (w || rvalid_i) ? rdata_i : 24'hffffff; // no answer never matches
   endtask : acc
   // interrupt service: view first, then clear
   task automatic service(output logic [23:0] v, output logic [23:0] c);
      acc(1'b0, 8'h19, 24'h000000, v);
      acc(1'b0, 8'h1a, 24'h000000, c);
   endtask : service
endmodule : mis_host_model
`default_nettype wire

// >>> bench/mis_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// checker on the flag block ports
// --------
module mis_status_assertions #(parameter int SRST_CYCLES = 10) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [23:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic [2:0] sag_i,
   input wire logic [2:0] zero_cross_i,
   input wire logic irq_n_o,
   input wire logic irq_oe_n_o,
   input wire logic soft_reset_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] sr_q; // clocks left in soft reset
   wire logic rd_v = reg_rd_i && reg_addr_i == 8'h19; // view read
   wire logic rd_c = reg_rd_i && reg_addr_i == 8'h1a; // clearing read
   wire logic rd_u = reg_rd_i && !(reg_addr_i inside {8'h13, 8'h18, 8'h19, 8'h1a});
   wire logic idle = !soft_reset_o && sr_q == 16'h0000; // no soft reset
   // two spare clocks keep the wait edges out
   always_ff @(posedge core_clk_i) begin
      sr_q <= rst_i ? 16'h0000 : soft_reset_o ? 16'(SRST_CYCLES + 2) :
         sr_q - 16'(sr_q != 16'h0000);
   end
   property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read unanswered");
   property p_quiet; !reg_rd_i |=> !reg_rvalid_o; endproperty
   a_quiet: assert property (p_quiet) else $error("stray rvalid");
   property p_pin; irq_oe_n_o == irq_n_o; endproperty
   a_pin: assert property (p_pin) else $error("pin enable differs");
   property p_upper; reg_rvalid_o |-> reg_rdata_o[23:20] == 4'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_unmap; rd_u |=> reg_rdata_o == 24'h000000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   property p_sticky;
      rd_v && idle ##1 !reg_rd_i ##1 rd_c && idle |=>
         (reg_rdata_o & $past(reg_rdata_o)) == $past(reg_rdata_o);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_sag;
      sag_i != 3'h0 ##1 !rd_c && !reg_wr_i ##1 rd_v |=>
         (reg_rdata_o[5:3] & $past(sag_i, 3)) == $past(sag_i, 3);
   endproperty
   a_sag: assert property (p_sag) else $error("sag flag missing");
   property p_zc;
      zero_cross_i != 3'h0 ##1 !rd_c && !reg_wr_i ##1 rd_v |=>
         (reg_rdata_o[11:9] & $past(zero_cross_i, 3)) == $past(zero_cross_i, 3);
   endproperty
   a_zc: assert property (p_zc) else $error("crossing flag missing");
   property p_hold;
      !irq_n_o && !rd_c && !reg_wr_i && !$past(reg_wr_i) && idle |=> !irq_n_o;
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped early");
   c_clear: cover property (rd_c && !irq_n_o);
   c_srst: cover property (soft_reset_o);
   c_sag: cover property (sag_i != 3'h0 ##2 rd_v);
endmodule : mis_status_assertions
bind mis_status mis_status_assertions #(.SRST_CYCLES(SRST_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> bench/mis_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// bench for the flag block
// --------
module mis_status_tb;
   localparam int SRC = 10; // short soft reset wait
   typedef struct {int src; logic [23:0] exp;} mis_row_t; // event bit, flags due
   logic core_clk_i, rst_i, rd, wr, rvalid, irq_n, oe_n, srst;
   logic [7:0] addr;
   logic [23:0] wdata, rdata, v, c, q;
   logic [23:0] stim; // every event input
   wire logic [23:0] irq_w = {23'h000000, irq_n};
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   mis_row_t rows [18] = '{'{0, 24'h000001}, '{4, 24'h000002}, '{8, 24'h000004},
      '{9, 24'h000008}, '{10, 24'h000010}, '{11, 24'h000020}, '{12, 24'h000040},
      '{13, 24'h000080}, '{14, 24'h000100}, '{15, 24'h000200}, '{16, 24'h080400},
      '{17, 24'h000800}, '{18, 24'h001000}, '{19, 24'h004000}, '{20, 24'h008000},
      '{21, 24'h010000}, '{22, 24'h020000}, '{23, 24'h040000}};
   mis_status #(.SRST_CYCLES(SRC)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .act_msb_i(stim[2:0]),
      .react_msb_i(stim[5:3]), .app_msb_i(stim[8:6]), .sag_i(stim[11:9]),
      .crossing_timeout_i(stim[14:12]), .zero_cross_i(stim[17:15]),
      .line_accum_done_i(stim[18]), .voltage_peak_flag_i(stim[19]),
      .current_peak_flag_i(stim[20]), .waveform_sample_ready_i(stim[21]),
      .active_power_sign_change_i(stim[22]), .reactive_power_sign_change_i(stim[23]),
      .irq_n_o(irq_n), .irq_oe_n_o(oe_n), .soft_reset_o(srst));
   mis_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
      .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one-cycle toggle of an event input
   task automatic pulse(input int s);
      stim[s] <= ~stim[s];
      @(posedge core_clk_i);
      stim[s] <= ~stim[s];
      @(posedge core_clk_i);
   endtask : pulse
   task automatic close_out;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   // hang guard
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 1000) begin
         n_fail++;
         close_out;
      end
   end
   initial begin
      rst_i = 1'b1;
      stim = 24'h000000;
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      chk(irq_w, 24'h000001, "irq");
      host.acc(1'b0, 8'h18, 24'h000000, q);
      chk(q, 24'h000000, "mask");
      host.acc(1'b0, 8'h20, 24'h000000, q);
      chk(q, 24'h000000, "unmapped");
      host.service(v, c);
      chk(v, 24'h002000, "view");
      chk(c, 24'h002000, "clear");
      $display("test reset done");
      pulse(9);
      chk(irq_w, 24'h000001, "masked irq");
      host.acc(1'b1, 8'h18, 24'h0fffff, q);
      @(posedge core_clk_i);
      chk(irq_w, 24'h000000, "enabled irq");
      host.service(v, c);
      chk(c, 24'h000008, "held flag");
      $display("test mask done");
      foreach (rows[i]) begin
         pulse(rows[i].src);
         chk(irq_w, 24'h000000, "irq");
         chk({23'h000000, oe_n}, 24'h000000, "pin enable");
         host.service(v, c);
         chk(v, rows[i].exp, "view");
         chk(c, rows[i].exp, "clear");
         chk(irq_w, 24'h000001, "released irq");
      end
      host.acc(1'b0, 8'h19, 24'h000000, q);
      chk(q, 24'h000000, "view after clear");
      $display("test events done");
      host.acc(1'b1, 8'h13, 24'h000040, q);
      chk({23'h000000, srst}, 24'h000001, "soft reset");
      host.acc(1'b0, 8'h18, 24'h000000, q);
      chk(q, 24'h000000, "mask in wait");
      host.acc(1'b0, 8'h19, 24'h000000, q);
      chk(q, 24'h000000, "view in wait");
      repeat (SRC) @(posedge core_clk_i);
      host.acc(1'b0, 8'h19, 24'h000000, q);
      chk(q, 24'h002000, "view after wait");
      $display("test soft reset done");
      close_out;
   end
endmodule : mis_status_tb
`default_nettype wire

// >>> core/mis_events.sv
`timescale 1ns/1ps
`default_nettype none
`include "mis_map.svh"
// ----------------------------------------
// edge detectors turning raw inputs into events
// ----------------------------------------
module mis_events (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [2:0] act_msb_i, // bit 14 of each active accumulator
   input wire logic [2:0] react_msb_i, // bit 14 of each reactive accumulator
   input wire logic [2:0] app_msb_i, // bit 15 of each apparent accumulator
   input wire logic [2:0] zc_i, // rising zero-crossing pulses a/b/c
   mis_evt_if.src ev,
   output logic [2:0] pending_o // unused spare view of sequence arming state
);
   logic [2:0] act_q, react_q, app_q; // previous samples
   logic seq_armed_q; // phase a crossing seen, awaiting next
   // ----------------------------------------
   // sample history
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         act_q <= 3'h0;
         react_q <= 3'h0;
         app_q <= 3'h0;
         seq_armed_q <= 1'b0;
      end else begin
         act_q <= act_msb_i;
         react_q <= react_msb_i;
         app_q <= app_msb_i;
         // arm on a, disarm on the next b or c
         if (zc_i[0]) begin
            seq_armed_q <= 1'b1;
         end else if (zc_i[1] || zc_i[2]) begin
            seq_armed_q <= 1'b0;
         end
      end
   end
   assign pending_o = {2'h0, seq_armed_q};
   // ----------------------------------------
   // event forming
   // ----------------------------------------
   assign ev.evt[`MIS_BIT_ACTIVE_ENERGY_HALF_FULL] = |(act_q ^ act_msb_i);
   assign ev.evt[`MIS_BIT_REACTIVE_ENERGY_HALF_FULL] = |(react_q ^ react_msb_i);
   assign ev.evt[`MIS_BIT_APPARENT_ENERGY_HALF_FULL] = |(~app_q & app_msb_i);
   // b after a with no c in between
   assign ev.evt[`MIS_BIT_SEQ] = seq_armed_q & zc_i[1] & ~zc_i[0];
   assign ev.evt[`MIS_BIT_PKI:`MIS_BIT_SAG] = 13'h0000; // filled by top
   assign ev.evt[`MIS_BIT_REVQ:`MIS_BIT_WAVE] = 3'h0; // filled by top
endmodule : mis_events
`default_nettype wire

// >>> core/mis_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "mis_map.svh"
// Function
// - events set flags regardless of mask
// - enabled set flag drives irq low
// - flags stay set until clearing read or soft reset
// - clearing read returns flags then clears
// - view read returns flags unchanged
// - flag 0 on active accumulator bit14 change
// - flag 1 on reactive accumulator bit14 change
// - flag 2 on apparent bit15 rising
// - flags 3-5 on sag a/b/c
// - flags 6-8 on missing crossing a/b/c
// - flags 9-11 on rising crossing a/b/c
// - flag 12 when line accumulation finishes
// - flag 13 166 us after soft reset
// - flags 14/15 on voltage/current peak
// - flag 16 on new waveform sample
// - flags 17/18 on power sign change
// - flag 19 when a followed by b
// - clearing read releases irq; mask separate
module mis_status import mis_pkg::*; #(
   parameter int SRST_CYCLES = `MIS_SRST_CYC // soft reset duration in clocks
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   // host register port, one access per strobe
   input wire logic reg_rd_i, // read strobe
   input wire logic reg_wr_i, // write strobe
   input wire logic [7:0] reg_addr_i, // register address
   input wire logic [23:0] reg_wdata_i, // write data
   output logic [23:0] reg_rdata_o, // read data, valid cycle after strobe
   output logic reg_rvalid_o, // read data valid pulse
   // raw event sources
   input wire logic [2:0] act_msb_i,
   input wire logic [2:0] react_msb_i,
   input wire logic [2:0] app_msb_i,
   input wire logic [2:0] sag_i,
   input wire logic [2:0] crossing_timeout_i,
   input wire logic [2:0] zero_cross_i,
   input wire logic line_accum_done_i,
   input wire logic voltage_peak_flag_i,
   input wire logic current_peak_flag_i,
   input wire logic waveform_sample_ready_i,
   input wire logic active_power_sign_change_i,
   input wire logic reactive_power_sign_change_i,
   // outputs
   output logic irq_n_o, // interrupt, low while asserted
   output logic irq_oe_n_o, // open-collector enable, low while driving
   output logic soft_reset_o // pulse: other registers to defaults
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   mis_flags_t flags_q, flags_d; // sticky event flags
   mis_flags_t mask_q; // interrupt enables
   logic [7:0] operating_mode_reg_q; // operating mode register
   mis_sr_t sr_q; // soft-reset sequencer
   logic [$clog2(SRST_CYCLES+1)-1:0] sr_cnt_q; // soft-reset timer
   logic [23:0] rdata_q; // read data holding
   logic rvalid_q; // read valid
   logic irq_n_q; // irq pin level, low while asserted
   logic srst_pulse_q; // soft-reset pulse
   mis_evt_if evb (); // detector events
   // ----------------------------------------
   // decoding
   // ----------------------------------------
   wire rd_view = reg_rd_i && (reg_addr_i == `MIS_ADDR_VIEW);
   wire rd_clear = reg_rd_i && (reg_addr_i == `MIS_ADDR_CLEAR);
   wire wr_mask = reg_wr_i && (reg_addr_i == `MIS_ADDR_MASK);
   wire wr_opm = reg_wr_i && (reg_addr_i == `MIS_ADDR_OPERATING_MODE_REG);
   wire srst_req = wr_opm && reg_wdata_i[`MIS_BIT_OPM_SRST];
   wire sr_done = (sr_q == MIS_SR_WAIT) && (sr_cnt_q == '0);
   mis_flags_t evt_all;
   // ----------------------------------------
   // event detectors
   // ----------------------------------------
   mis_events u_events (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .act_msb_i(act_msb_i),
      .react_msb_i(react_msb_i),
      .app_msb_i(app_msb_i),
      .zc_i(zero_cross_i),
      .ev(evb.src),
      .pending_o()
   );
   // ----------------------------------------
   // event vector assembly
   // ----------------------------------------
   assign evt_all[2:0] = evb.evt[2:0];
   assign evt_all[`MIS_BIT_SAG+2:`MIS_BIT_SAG] = sag_i;
   assign evt_all[`MIS_BIT_ZXTO+2:`MIS_BIT_ZXTO] = crossing_timeout_i;
   assign evt_all[`MIS_BIT_ZX+2:`MIS_BIT_ZX] = zero_cross_i;
   assign evt_all[`MIS_BIT_LACC] = line_accum_done_i;
   assign evt_all[`MIS_BIT_SRST] = sr_done;
   assign evt_all[`MIS_BIT_PKV] = voltage_peak_flag_i;
   assign evt_all[`MIS_BIT_PKI] = current_peak_flag_i;
   assign evt_all[`MIS_BIT_WAVE] = waveform_sample_ready_i;
   assign evt_all[`MIS_BIT_REVP] = active_power_sign_change_i;
   assign evt_all[`MIS_BIT_REVQ] = reactive_power_sign_change_i;
   assign evt_all[`MIS_BIT_SEQ] = evb.evt[`MIS_BIT_SEQ];
   // ----------------------------------------
   // flag next state
   // ----------------------------------------
   always_comb begin
      flags_d = flags_q;
      // clearing read returns all flags to zero
      if (rd_clear) begin
         flags_d = '0;
      end
      // soft reset in progress forces defaults, minus the done bit
      if (sr_q == MIS_SR_WAIT) begin
         flags_d = '0;
      end
      // set wins over clear, mask ignored
      flags_d = flags_d | evt_all;
   end
   // ----------------------------------------
   // flag and mask registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flags_q <= `MIS_FLAGS_RESET;
         mask_q <= `MIS_MASK_RESET;
      end else begin
         flags_q <= flags_d;
         // mask sits at its own address; defaults on soft reset
         if (sr_q == MIS_SR_WAIT) begin
            mask_q <= `MIS_MASK_RESET;
         end else if (wr_mask) begin
            mask_q <= reg_wdata_i[19:0];
         end
      end
   end
   // ----------------------------------------
   // operating mode and soft reset timer
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         operating_mode_reg_q <= 8'h00;
         sr_q <= MIS_SR_IDLE;
         sr_cnt_q <= '0;
         srst_pulse_q <= 1'b0;
      end else begin
         srst_pulse_q <= 1'b0;
         unique case (sr_q)
            MIS_SR_IDLE: begin
               if (srst_req) begin
                  sr_q <= MIS_SR_WAIT;
                  sr_cnt_q <= ($clog2(SRST_CYCLES+1))'(SRST_CYCLES - 1);
                  operating_mode_reg_q <= 8'h00;
                  srst_pulse_q <= 1'b1;
               end else if (wr_opm) begin
                  operating_mode_reg_q <= reg_wdata_i[7:0];
               end
            end
            MIS_SR_WAIT: begin
               // count down; done bit sets when zero reached
               if (sr_cnt_q == '0) begin
                  sr_q <= MIS_SR_IDLE;
               end else begin
                  sr_cnt_q <= sr_cnt_q - 1'b1;
               end
            end
         endcase
      end
   end
   // ----------------------------------------
   // read data path
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_q <= 24'h000000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (rd_view || rd_clear) begin
            rdata_q <= {4'h0, flags_q};
         end else if (reg_rd_i && reg_addr_i == `MIS_ADDR_MASK) begin
            rdata_q <= {4'h0, mask_q};
         end else if (reg_rd_i && reg_addr_i == `MIS_ADDR_OPERATING_MODE_REG) begin
            rdata_q <= {16'h0000, operating_mode_reg_q};
         end else if (reg_rd_i) begin
            rdata_q <= 24'h000000; // unmapped reads zero
         end
      end
   end
   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_n_q <= 1'b1;
      end else begin
         // pin straight from this flop, low while any enabled flag stands
         irq_n_q <= ~|(flags_d & mask_q);
      end
   end
   assign irq_n_o = irq_n_q;
   assign irq_oe_n_o = irq_n_q;
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign soft_reset_o = srst_pulse_q;
endmodule : mis_status
`default_nettype wire

// >>> shared/mis_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// one-cycle event vector from the detector stage to the flag store
interface mis_evt_if;
   logic [19:0] evt; // event pulses, one per flag
   modport src (output evt);
   modport dst (input evt);
endinterface : mis_evt_if
`default_nettype wire

// >>> shared/mis_map.svh
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define MIS_ADDR_MASK 8'h18
`define MIS_ADDR_VIEW 8'h19
`define MIS_ADDR_CLEAR 8'h1a
`define MIS_ADDR_OPERATING_MODE_REG 8'h13
// ----------------------------------------
// field positions
// ----------------------------------------
`define MIS_NUM_FLAGS 20
`define MIS_BIT_ACTIVE_ENERGY_HALF_FULL 0
`define MIS_BIT_REACTIVE_ENERGY_HALF_FULL 1
`define MIS_BIT_APPARENT_ENERGY_HALF_FULL 2
`define MIS_BIT_SAG 3
`define MIS_BIT_ZXTO 6
`define MIS_BIT_ZX 9
`define MIS_BIT_LACC 12
`define MIS_BIT_SRST 13
`define MIS_BIT_PKV 14
`define MIS_BIT_PKI 15
`define MIS_BIT_WAVE 16
`define MIS_BIT_REVP 17
`define MIS_BIT_REVQ 18
`define MIS_BIT_SEQ 19
`define MIS_BIT_OPM_SRST 6
`define MIS_ACC_HALF_BIT 14
`define MIS_APP_HALF_BIT 15
// ----------------------------------------
// reset values
// ----------------------------------------
`define MIS_FLAGS_RESET 20'h02000
`define MIS_MASK_RESET 20'h00000
// ----------------------------------------
// timing
// ----------------------------------------
`define MIS_CLK_MHZ 50
`define MIS_SRST_NS 166000
`define MIS_SRST_CYC ((`MIS_SRST_NS * `MIS_CLK_MHZ + 999) / 1000)
`endif

// >>> shared/mis_pkg.sv
package mis_pkg;
   // flag vector type
   typedef logic [19:0] mis_flags_t;
   // host access kinds
   typedef enum logic [1:0] {
      MIS_ACC_NONE = 2'b00,
      MIS_ACC_READ = 2'b01,
      MIS_ACC_WRITE = 2'b10
   } mis_acc_t;
   // soft-reset sequencer states
   typedef enum logic [0:0] {
      MIS_SR_IDLE = 1'b0,
      MIS_SR_WAIT = 1'b1
   } mis_sr_t;
endpackage : mis_pkg
